// >>> conv_regs.v
// Status reporting, gain/offset correction and overrange detection of the converter back end
// What this block does
// - Status bits 15:14 hold fixed part code
// - Status bits 13:11 hold die instance code
// - Status bit 10 always reads zero
// - Status bit 9 shows reduced power mode
// - Status bit 8 set when input exceeds threshold
// - Bit 7 set when download checksum matches
// - Bit 6 set when filter pass checksum matches
// - Bit 5 set when custom filter in use
// - Bit 4 set when FIR stage bypassed
// - Bit 3 set when first stage bypassed
// - Bits 2:0 mirror programmed decimation code
// - Offset at address 3, signed, resets zero
// - Full offset code is 0.78125 percent scale
// - Offset applied after gain correction
// - Gain at address 4, resets 0xA000, 0x8000 unity
// - Threshold at address 5, compared before correction
// - Overrange clears the sample valid flag
// - Over four full-scale modulator samples set overrange
`timescale 1ns/100ps
`include "conv_regs_defs.vh"
module conv_regs #(
    parameter [1:0] PART_CODE = 2'h1, // Arbitrary value
    parameter [2:0] DIE_CODE = 3'h2 // Arbitrary value
) (
    input wire ref_clk_i, // Core clock, 250 MHz
    input wire rst_b_i, // Async reset, active low
    input wire [2:0] addr_i, // Register address
    input wire [15:0] wdata_i, // Write data
    input wire wr_i, // Write strobe
    input wire rd_i, // Read strobe
    output reg [15:0] rdata_o, // Read data, cycle after rd_i
    input wire [23:0] sample_i, // Filtered sample, signed
    input wire sample_vld_i, // Sample strobe
    input wire [15:0] stage1_i, // First decimation stage output, signed
    input wire stage1_vld_i, // Stage one strobe
    input wire mod_full_i, // Modulator sample beyond full reference
    input wire mod_vld_i, // Modulator rate strobe
    input wire coef_pass_i, // Coefficient flowing through filter
    input wire [15:0] coef_pass_data_i, // That coefficient
    input wire coef_pass_done_i, // Pass checksum complete
    output reg [23:0] result_o, // Corrected sample
    output reg result_vld_o, // Corrected sample strobe
    output reg sample_valid_flag_o, // Data valid status for output word
    output reg input_excess_flag_o // Overrange indication
);
    // ----------------------------------------
    // Control and correction registers
    // ----------------------------------------
    reg [15:0] ctrl1_reg;
    reg [15:0] ctrl2_reg;
    reg [15:0] offset_correction_reg;
    reg [15:0] gain_correction_reg;
    reg [15:0] overrange_threshold_reg;
    reg [3:0] read_sel_reg;
    reg download_reg;
    reg [3:0] coef_left_reg;
    reg [15:0] load_sum_ref_reg;
    reg load_checksum_match_reg;
    reg coefficient_pass_match_reg;
    reg custom_fir_active_reg;
    reg [2:0] full_run_reg;
    wire [15:0] load_sum;
    wire [15:0] pass_sum;
    wire dl_word = wr_i && download_reg;
    wire dl_coef = dl_word && (coef_left_reg != 4'h0);
    wire dl_last = dl_word && (coef_left_reg == 4'h0);
    // While a download is armed no write reaches the register map
    wire map_wr = wr_i && !download_reg;
    wire dl_arm = map_wr && (addr_i == `ADDR_CTRL1) && wdata_i[`C1_DL_FILT];
    // Next values of the run counter and the output flops
    reg [2:0] full_run_next;
    reg excess_next;
    reg [23:0] result_next;
    reg valid_next;
    reg [15:0] read_next;

    // ----------------------------------------
    // Status fields mirrored from control state
    // ----------------------------------------
    wire reduced_power_flag = ctrl2_reg[`C2_LOWPWR];
    // Control bits enable a stage; the status bits report it skipped
    wire fir_stage_skip_flag = ~ctrl1_reg[`C1_FIR_EN];
    wire first_stage_skip_flag = ~ctrl1_reg[`C1_FIRST_EN];
    wire [2:0] rate_reduction_code = ctrl1_reg[2:0];

    // ----------------------------------------
    // Register map writes
    // ----------------------------------------
    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            ctrl1_reg <= `CTRL1_RESET;
            ctrl2_reg <= `CTRL2_RESET;
            offset_correction_reg <= `OFFSET_RESET;
            gain_correction_reg <= `GAIN_RESET;
            overrange_threshold_reg <= `THRESH_RESET;
        end
        else if (map_wr)
        begin
            // Self-clearing request bits are not kept in the register
            if (addr_i == `ADDR_CTRL1)
                ctrl1_reg <= {7'h00, wdata_i[8:0]};
            else if (addr_i == `ADDR_CTRL2)
                ctrl2_reg <= wdata_i;
            else if (addr_i == `ADDR_OFFSET)
                offset_correction_reg <= wdata_i;
            else if (addr_i == `ADDR_GAIN)
                gain_correction_reg <= wdata_i;
            else if (addr_i == `ADDR_THRESH)
                overrange_threshold_reg <= wdata_i;
            // Any other address, including status, is dropped
        end
    end

    // ----------------------------------------
    // Read request selector
    // ----------------------------------------
    // One request bit each for status, offset, gain and threshold; a read consumes it, so the next read returns to the address map
    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            read_sel_reg <= 4'h0;
        else if (map_wr && addr_i == `ADDR_CTRL1)
            read_sel_reg <= wdata_i[`C1_RD_THRESH:`C1_RD_STATUS];
        else if (rd_i && !wr_i)
            read_sel_reg <= 4'h0;
    end

    // ----------------------------------------
    // Coefficient download sequencer
    // ----------------------------------------
    // Writes while armed are coefficients until the count runs out; the word after the last one is the checksum
    // Coefficients themselves are not stored here, only their running sum
    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            download_reg <= 1'b0;
            coef_left_reg <= 4'h0;
            load_sum_ref_reg <= 16'h0000;
            load_checksum_match_reg <= 1'b0;
            custom_fir_active_reg <= 1'b0;
        end
        else if (dl_coef)
            coef_left_reg <= coef_left_reg - 4'h1;
        else if (dl_last)
        begin
            download_reg <= 1'b0;
            load_sum_ref_reg <= wdata_i;
            load_checksum_match_reg <= (wdata_i == load_sum);
            custom_fir_active_reg <= 1'b1;
        end
        else if (dl_arm)
        begin
            download_reg <= 1'b1;
            coef_left_reg <= wdata_i[8:5];
            load_checksum_match_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Checksum units
    // ----------------------------------------
    // One sum follows the download, the other the coefficients seen in the filter
    fir_checksum load_ck (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .clear_i(dl_arm),
        .add_i(dl_coef),
        .word_i(wdata_i),
        .sum_o(load_sum)
    );

    fir_checksum pass_ck (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .clear_i(coef_pass_done_i),
        .add_i(coef_pass_i),
        .word_i(coef_pass_data_i),
        .sum_o(pass_sum)
    );

    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            coefficient_pass_match_reg <= 1'b0;
        // Judged only when a pass ends, against the stored download checksum
        else if (coef_pass_done_i)
            coefficient_pass_match_reg <= custom_fir_active_reg && (pass_sum == load_sum_ref_reg);
    end

    // ----------------------------------------
    // Overrange detection
    // ----------------------------------------
    // Magnitude of stage one output against threshold, before any correction
    wire [15:0] stage1_mag = stage1_i[15] ? (~stage1_i + 16'h0001) : stage1_i;
    // Saturating run counter, so a long overload cannot wrap back below the limit
    wire run_done = mod_vld_i && mod_full_i && (full_run_reg >= `FULL_SCALE_RUN);
    always @*
    begin
        full_run_next = full_run_reg;
        if (mod_vld_i)
        begin
            if (!mod_full_i)
                full_run_next = 3'h0;
            else if (full_run_reg != 3'h7)
                full_run_next = full_run_reg + 3'h1;
        end
    end

    // A full-scale run sets the flag even when stage one would clear it in the same cycle
    always @*
    begin
        excess_next = input_excess_flag_o;
        if (run_done)
            excess_next = 1'b1;
        else if (stage1_vld_i)
            excess_next = (stage1_mag > overrange_threshold_reg);
    end

    // Registered so the flag leaves the block straight from a flop
    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            full_run_reg <= 3'h0;
            input_excess_flag_o <= 1'b0;
        end
        else
        begin
            full_run_reg <= full_run_next;
            input_excess_flag_o <= excess_next;
        end
    end

    // ----------------------------------------
    // Gain then offset correction
    // ----------------------------------------
    // Gain is unsigned Q1.15; offset full code spans 2^-7 of full scale
    wire signed [40:0] gain_prod = $signed(sample_i) * $signed({1'b0, gain_correction_reg});
    wire signed [25:0] gained = gain_prod[40:15];
    wire signed [25:0] off_wide = {{10{offset_correction_reg[15]}}, offset_correction_reg};
    wire signed [25:0] off_scaled = off_wide <<< `OFFSET_SHIFT;
    wire signed [25:0] sum_corr = gained + off_scaled;
    wire signed [25:0] max_pos = 26'sh07FFFFF;
    wire signed [25:0] max_neg = -26'sh0800000;

    // Clamp rather than wrap, so an overloaded sum keeps its sign
    always @*
    begin
        result_next = result_o;
        valid_next = sample_valid_flag_o;
        if (sample_vld_i)
        begin
            // Offset after gain so its range is independent of gain
            if (sum_corr > max_pos)
                result_next = 24'h7FFFFF;
            else if (sum_corr < max_neg)
                result_next = 24'h800000;
            else
                result_next = sum_corr[23:0];
            valid_next = !input_excess_flag_o;
        end
    end

    // Result strobe follows the sample strobe by exactly one cycle
    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            result_o <= 24'h000000;
            result_vld_o <= 1'b0;
            sample_valid_flag_o <= 1'b0;
        end
        else
        begin
            result_o <= result_next;
            result_vld_o <= sample_vld_i;
            sample_valid_flag_o <= valid_next;
        end
    end

    // ----------------------------------------
    // Status word and readback
    // ----------------------------------------
    wire [15:0] status_word = {
        PART_CODE,
        DIE_CODE,
        1'b0,
        reduced_power_flag,
        input_excess_flag_o,
        load_checksum_match_reg,
        coefficient_pass_match_reg,
        custom_fir_active_reg,
        fir_stage_skip_flag,
        first_stage_skip_flag,
        rate_reduction_code
    };

    // ----------------------------------------
    // Readback
    // ----------------------------------------
    // A pending request bit outranks the address; address 1 and unmapped addresses fall back to status
    always @*
    begin
        read_next = 16'h0000;
        if (rd_i)
        begin
            if (read_sel_reg[0])
                read_next = status_word;
            else if (read_sel_reg[1])
                read_next = offset_correction_reg;
            else if (read_sel_reg[2])
                read_next = gain_correction_reg;
            else if (read_sel_reg[3])
                read_next = overrange_threshold_reg;
            else if (addr_i == `ADDR_CTRL2)
                read_next = ctrl2_reg;
            else if (addr_i == `ADDR_OFFSET)
                read_next = offset_correction_reg;
            else if (addr_i == `ADDR_GAIN)
                read_next = gain_correction_reg;
            else if (addr_i == `ADDR_THRESH)
                read_next = overrange_threshold_reg;
            else
                read_next = status_word;
        end
    end

    // Zero outside the read slot keeps a shared data bus quiet between reads
    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rdata_o <= 16'h0000;
        else
            rdata_o <= read_next;
    end
endmodule // conv_regs

// >>> conv_regs_asserts.sv
// Port-level checks for the converter register bank
`timescale 1ns/100ps
module conv_regs_asserts #(
    parameter [1:0] PART_CODE = 2'h1, // Arbitrary value
    parameter [2:0] DIE_CODE = 3'h2 // Arbitrary value
) (
    input wire ref_clk_i, // Clock
    input wire rst_b_i, // Reset, active low
    input wire [2:0] addr_i, // Address
    input wire [15:0] wdata_i, // Write data
    input wire wr_i, // Write strobe
    input wire rd_i, // Read strobe
    input wire [15:0] rdata_o, // Read data
    input wire [23:0] sample_i, // Sample
    input wire sample_vld_i, // Sample strobe
    input wire [15:0] stage1_i, // Stage one data
    input wire stage1_vld_i, // Stage one strobe
    input wire mod_full_i, // Full-scale bit
    input wire mod_vld_i, // Modulator strobe
    input wire [23:0] result_o, // Result
    input wire result_vld_o, // Result strobe
    input wire sample_valid_flag_o, // Valid flag
    input wire input_excess_flag_o // Overrange flag
);
// ----------------------------------------
// Shadow state
// ----------------------------------------
// Shadows assume no coefficient download is aimed at addresses 3 to 5
reg [15:0] off_reg;
reg [15:0] gain_reg;
reg [15:0] thr_reg;
reg [2:0] full_reg;
wire [15:0] mag = stage1_i[15] ? 16'h0000 - stage1_i : stage1_i;
always @(posedge ref_clk_i or negedge rst_b_i)
begin
    if (!rst_b_i)
    begin
        off_reg <= 16'h0000;
        gain_reg <= 16'hA000;
        thr_reg <= 16'hCCCC;
        full_reg <= 3'h0;
    end
    else
    begin
        if (wr_i && addr_i == 3'h3)
            off_reg <= wdata_i;
        if (wr_i && addr_i == 3'h4)
            gain_reg <= wdata_i;
        if (wr_i && addr_i == 3'h5)
            thr_reg <= wdata_i;
        if (mod_vld_i)
            full_reg <= !mod_full_i ? 3'h0 : (full_reg == 3'h4 ? 3'h4 : full_reg + 3'h1);
    end
end
default clocking cb @(posedge ref_clk_i); endclocking
default disable iff (!rst_b_i);
sequence stat_rd;
    wr_i && addr_i == 3'h1 && wdata_i[11] && !wdata_i[15] ##1 rd_i;
endsequence
a_read_idle: assert property (!rd_i |=> rdata_o == 16'h0000) else $error("read data outside read slot");
a_status_ident: assert property (stat_rd |=> rdata_o[15:11] == {PART_CODE, DIE_CODE})
    else $error("status identity bits wrong");
a_status_zero: assert property (stat_rd |=> !rdata_o[10]) else $error("status bit ten set");
a_over_thresh: assert property (stage1_vld_i && mag > thr_reg |=> input_excess_flag_o)
    else $error("overrange not flagged above threshold");
a_five_full: assert property (mod_vld_i && mod_full_i && full_reg == 3'h4 && !stage1_vld_i |=> input_excess_flag_o)
    else $error("overrange not flagged after five full samples");
a_excess_valid: assert property (sample_vld_i && input_excess_flag_o && !stage1_vld_i |=> !sample_valid_flag_o)
    else $error("valid flag kept during overrange");
a_unity_corr: assert property (sample_vld_i && gain_reg == 16'h8000 && !wr_i
    |=> result_o == $past(sample_i) + {{7{off_reg[15]}}, off_reg, 1'b0}) else $error("unity gain result wrong");
a_result_pulse: assert property (sample_vld_i ##1 !sample_vld_i |-> result_vld_o ##1 !result_vld_o)
    else $error("result strobe not one cycle");
cover property (sample_vld_i && input_excess_flag_o);
cover property (full_reg == 3'h4 && mod_vld_i);
cover property (stat_rd);
endmodule // conv_regs_asserts
bind conv_regs conv_regs_asserts #(.PART_CODE(PART_CODE), .DIE_CODE(DIE_CODE)) i_chk (.ref_clk_i, .rst_b_i,
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sample_i, .sample_vld_i, .stage1_i, .stage1_vld_i,
    .mod_full_i, .mod_vld_i, .result_o, .result_vld_o, .sample_valid_flag_o, .input_excess_flag_o);

// >>> conv_regs_defs.vh
// Register offsets, field positions, reset values and timing counts for the converter register bank
`ifndef CONV_REGS_DEFS_VH
`define CONV_REGS_DEFS_VH

`define ADDR_CTRL1 3'h1
`define ADDR_CTRL2 3'h2
`define ADDR_OFFSET 3'h3
`define ADDR_GAIN 3'h4
`define ADDR_THRESH 3'h5

`define OFFSET_RESET 16'h0000
`define GAIN_RESET 16'hA000
`define THRESH_RESET 16'hCCCC
`define CTRL1_RESET 16'h001B
`define CTRL2_RESET 16'h009B

`define C1_DL_FILT 15
`define C1_RD_THRESH 14
`define C1_RD_GAIN 13
`define C1_RD_OFFSET 12
`define C1_RD_STATUS 11
`define C1_FIR_EN 4
`define C1_FIRST_EN 3
`define C2_LOWPWR 2

`define ST_PART_HI 15
`define ST_DIE_HI 13
`define ST_ZERO 10
`define ST_LOWPWR 9
`define ST_EXCESS 8
`define ST_LOAD_OK 7
`define ST_PASS_OK 6
`define ST_CUSTOM 5
`define ST_FIR_SKIP 4
`define ST_FIRST_SKIP 3

`define FULL_SCALE_RUN 3'h4
// Offset LSB weighs two result LSBs: 2^15 codes span 2^-7 of a 2^23 full scale
`define OFFSET_SHIFT 1

`endif

// >>> conv_regs_tb.sv
// Self-checking bench for the converter register bank
`timescale 1ns/100ps
module conv_regs_tb;
reg clk = 1'b0;
reg rst_b = 1'b0;
reg [23:0] smp = 24'h0;
reg svld = 1'b0;
reg [15:0] s1 = 16'h0;
reg s1vld = 1'b0;
reg mfull = 1'b0;
reg mvld = 1'b0;
reg cpass = 1'b0;
reg [15:0] cdata = 16'h0;
reg cdone = 1'b0;
wire [2:0] addr;
wire [15:0] wdata;
wire wr;
wire rd;
wire [15:0] rdata;
wire [23:0] res;
wire rvld;
wire vflag;
wire xflag;
reg [15:0] d;
integer n_mismatch = 0;
integer n_checks = 0;
integer i;
always #2 clk = ~clk;
host_bus_model i_host (.ref_clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
conv_regs i_dut (.ref_clk_i(clk), .rst_b_i(rst_b), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .sample_i(smp), .sample_vld_i(svld), .stage1_i(s1), .stage1_vld_i(s1vld),
    .mod_full_i(mfull), .mod_vld_i(mvld), .coef_pass_i(cpass), .coef_pass_data_i(cdata),
    .coef_pass_done_i(cdone), .result_o(res), .result_vld_o(rvld), .sample_valid_flag_o(vflag),
    .input_excess_flag_o(xflag));
// ----------------------------------------
// Shared tasks
// ----------------------------------------
task chk(input [23:0] seen, input [23:0] exp);
begin
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
end
endtask
task summarize;
begin
    if (n_mismatch == 0 && n_checks > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
end
endtask
task samp(input [23:0] s, input [23:0] e, input v);
begin
    @(posedge clk);
    smp <= s;
    svld <= 1'b1;
    @(posedge clk);
    svld <= 1'b0;
    #1 chk({rvld, vflag, res}, {1'b1, v, e});
end
endtask
task stage(input [15:0] v, input e);
begin
    @(posedge clk);
    s1 <= v;
    s1vld <= 1'b1;
    @(posedge clk);
    s1vld <= 1'b0;
    #1 chk(xflag, e);
end
endtask
task pulse_mod;
begin
    @(posedge clk);
    mfull <= 1'b1;
    mvld <= 1'b1;
    @(posedge clk);
    mvld <= 1'b0;
end
endtask
// ----------------------------------------
// Scenarios
// ----------------------------------------
task t_status;
begin
    i_host.stat(16'h0015, d);
    chk(d, 16'h500D);
    i_host.wr(3'h2, 16'h0006);
    i_host.wr(3'h0, 16'hFFFF);
    i_host.stat(16'h000A, d);
    chk(d, 16'h5212);
end
endtask
task t_corr;
begin
    i_host.rd(3'h3, d);
    chk(d, 16'h0000);
    i_host.rd(3'h4, d);
    chk(d, 16'hA000);
    i_host.rd(3'h5, d);
    chk(d, 16'hCCCC);
    samp(24'h000400, 24'h000500, 1'b1);
    i_host.wr(3'h3, 16'h0010);
    samp(24'h000400, 24'h000520, 1'b1);
    samp(24'hFFFC00, 24'hFFFB20, 1'b1);
    i_host.wr(3'h4, 16'h8000);
    i_host.wr(3'h3, 16'h7FFF);
    samp(24'h000000, 24'h00FFFE, 1'b1);
    i_host.wr(3'h3, 16'h8000);
    samp(24'h123456, 24'h113456, 1'b1);
    i_host.wr(3'h3, 16'h0000);
end
endtask
task t_over;
begin
    i_host.wr(3'h5, 16'h1000);
    stage(16'h1001, 1'b1);
    samp(24'h000100, 24'h000100, 1'b0);
    stage(16'h0100, 1'b0);
    samp(24'h000100, 24'h000100, 1'b1);
    stage(16'hE000, 1'b1);
    stage(16'h0100, 1'b0);
    for (i = 0; i < 5; i = i + 1)
    begin
        pulse_mod;
        #1 chk(xflag, i == 4);
    end
    @(posedge clk);
    mfull <= 1'b0;
    i_host.stat(16'h0015, d);
    chk(d[8], 1'b1);
    stage(16'h0100, 1'b0);
end
endtask
task t_load;
begin
    for (i = 0; i < 2; i = i + 1)
    begin
        i_host.wr(3'h1, 16'h8055);
        i_host.wr(3'h0, 16'h1234);
        i_host.wr(3'h0, 16'h0101);
        i_host.wr(3'h0, i ? 16'h1335 : 16'h0000);
        i_host.stat(16'h0015, d);
        chk(d[7], i);
    end
    chk(d[5], 1'b1);
    @(posedge clk);
    cpass <= 1'b1;
    cdata <= 16'h1234;
    @(posedge clk);
    cdata <= 16'h0101;
    @(posedge clk);
    cpass <= 1'b0;
    cdata <= 16'hFEFE;
    cdone <= 1'b1;
    @(posedge clk);
    cdone <= 1'b0;
    i_host.stat(16'h0015, d);
    chk(d[6], 1'b1);
end
endtask
initial
begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_status;
    t_corr;
    t_over;
    t_load;
    summarize;
end
initial
begin
    #20000;
    n_mismatch = n_mismatch + 1;
    summarize;
end
endmodule // conv_regs_tb

// >>> fir_checksum.v
// Running checksum accumulator used for coefficient download and filter pass checks
`timescale 1ns/100ps
module fir_checksum (
    input wire ref_clk_i, // Core clock
    input wire rst_b_i, // Async reset, active low
    input wire clear_i, // Restart sum
    input wire add_i, // Accumulate word
    input wire [15:0] word_i, // Word to add
    output reg [15:0] sum_o // Running sum
);
    always @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            sum_o <= 16'h0000;
        else if (clear_i)
            sum_o <= 16'h0000;
        else if (add_i)
            sum_o <= sum_o + word_i;
    end
endmodule // fir_checksum

// >>> host_bus_model.sv
// Host processor model on the parallel register port
`timescale 1ns/100ps
module host_bus_model (
    input wire ref_clk_i, // Clock
    input wire [15:0] rdata_i, // Read data
    output reg [2:0] addr_o, // Address
    output reg [15:0] wdata_o, // Write data
    output reg wr_o, // Write strobe
    output reg rd_o // Read strobe
);
initial
begin
    addr_o = 3'h0;
    wdata_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
end
// Data lines are inverted after each write so stale values never look valid
task wr(input [2:0] a, input [15:0] d);
begin
    @(posedge ref_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge ref_clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
end
endtask
task rd(input [2:0] a, output [15:0] d);
begin
    @(posedge ref_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge ref_clk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
end
endtask
task stat(input [15:0] ctl, output [15:0] d);
begin
    wr(3'h1, ctl | 16'h0800);
    addr_o <= 3'h0;
    rd_o <= 1'b1;
    @(posedge ref_clk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
end
endtask
endmodule // host_bus_model
